// file: include/arc_pkg.sv
// package: register offsets, field positions and reset values for the analog ref/cal block
package arc_pkg;

  // register addresses on the special-function register bus
  localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h00_A2;
  localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h00_A3;
  localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'h00_C7;
  localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'h00_D1;

  // reference control field positions
  localparam int REF_OVERRIDE_BIT = 4;
  localparam int REF_SELECT_BIT = 3;
  localparam int REF_TEMP_EN_BIT = 2;
  localparam logic [7:0] REF_WRITE_MASK = 8'h00_1C;
  localparam logic [7:0] REF_RESET = 8'h00_00;

  // regulator control field positions; bits 5:0 kept as plain storage
  localparam int REG_STOP_CFG_BIT = 7;
  localparam int REG_BYPASS_BIT = 6;
  localparam logic [7:0] REG_RESET = 8'h00_00;

  // offset layout: 10-bit value, left-justified over two bytes
  localparam int OFFSET_WIDTH = 10;
  localparam int OFFSET_LOW_BITS = 2;
  localparam int OFFSET_LOW_POS = 6;
  localparam logic [7:0] OFFSET_LOW_MASK = 8'h00_C0;

  // per-part default offset, arbitrary value (replaced by the trimmed value at build)
  localparam logic [9:0] OFFSET_DEFAULT = 10'h0_200;

  // converter reference source codes
  typedef enum logic [2:0] {
    ARC_REF_PIN = 3'b001,
    ARC_REF_SUPPLY = 3'b010,
    ARC_REF_REGULATOR = 3'b100
  } arc_ref_src_t;

  // special-function register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arc_sfr_req_t;

  // analog control outputs
  typedef struct packed {
    arc_ref_src_t ref_src;
    logic temp_sensor_enable;
    logic stop_power_config;
    logic regulator_bypass;
  } arc_analog_ctl_t;

endpackage

// file: rtl/arc_offset_store.sv
// offset store: the 10-bit trimmed sensor offset, register-read output
`timescale 1ns/1ps
module arc_offset_store (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_wr_high,
  input wire logic i_wr_low,
  input wire logic [7:0] i_wdata,
  input wire logic i_sel_high,
  output logic [7:0] o_rdata,
  output logic [9:0] o_offset
);

  logic [9:0] offset_r;

  // high byte holds 9:2, low byte 7:6 holds 1:0; low 5:0 writes dropped
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      offset_r <= arc_pkg::OFFSET_DEFAULT;
    end else begin
      if (i_wr_high) begin
        offset_r[9:2] <= i_wdata;
      end
      if (i_wr_low) begin
        offset_r[1:0] <= i_wdata[7:6];
      end
    end
  end

  // registered read data, low byte zero-filled below bit 6
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00_00;
    end else if (i_sel_high) begin
      o_rdata <= offset_r[9:2];
    end else begin
      o_rdata <= {offset_r[1:0], 6'b00_0000};
    end
  end

  assign o_offset = offset_r;

endmodule // arc_offset_store

// file: rtl/arc_analog_regs.sv
// analog reference, regulator and sensor-calibration register bank
//
// What this block does
// - offset left-justified: 9:2 high, 1:0 at 7:6
// - offset resets to per-part trimmed value
// - one offset step equals one converter step
// - low byte bits 5:0 read zero
// - override bit forces internal regulator reference
// - override clear lets select bit decide
// - select 0 pin, 1 supply
// - bit 2 drives temperature sensor enable
// - reference bits 7:5, 1:0 read zero
// - default keeps regulator on in stop
// - stop config 1 shuts regulator in stop
// - stop config at bit 7, resets 0
// - bypass at bit 6, resets 0
//
// design notes for whoever picks this up next:
// - all four registers sit on one byte-wide special-function bus; a write
//   lands on the edge that samples wr high, a read answers one cycle later
// - read data and the hit flag come from flip-flops, so the read path never
//   ripples the live address straight into the core's data mux
// - the reference source is one-hot and registered once more after the
//   stored control bits, so the analog switch sees a clean, glitch-free code
//   even when override and select change in the same write
// - the offset is held as the raw converter code; nothing here rescales it,
//   which keeps one stored step equal to one converter step
// - the low offset byte keeps only its two top bits; the rest reads zero
// - bypass is taken as written: nothing stops software from setting it with
//   no outside supply present, and that limit must stay with the firmware
// - stop-mode shutdown is reported as a level for the power controller; the
//   reset tree outside decides what a pin-only reset means
// - regulator control bits 5:0 are kept as plain storage with no function
//   here; the memory power controller that owns bit 0 lives elsewhere
// - unmapped addresses answer with hit low and data zero; writes to them
//   are dropped without any side effect
`timescale 1ns/1ps
module arc_analog_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire arc_pkg::arc_sfr_req_t i_sfr,
  input wire logic i_stop_mode,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output arc_pkg::arc_analog_ctl_t o_ctl,
  output logic o_regulator_on,
  output logic o_stop_reset_pin_only,
  output logic [9:0] o_sensor_offset_value
);

  logic [7:0] ref_ctl_r;
  logic [7:0] reg_ctl_r;
  logic [7:0] ref_rdata_r;
  logic [7:0] off_rdata;
  logic rd_offset_r;
  logic hit_r;
  arc_pkg::arc_ref_src_t ref_src_r;
  arc_pkg::arc_ref_src_t ref_src_nxt;

  // address match helper, used for every register
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // register map slots: one comparator per mapped address
  localparam int NUM_REGS = 4;
  localparam int IDX_OFF_LOW = 0;
  localparam int IDX_OFF_HIGH = 1;
  localparam int IDX_REG = 2;
  localparam int IDX_REF = 3;

  // slot number to register address
  function automatic logic [7:0] reg_addr(input int idx);
    case (idx)
      IDX_OFF_LOW: begin
        reg_addr = arc_pkg::ADDR_TEMP_OFFSET_LOW;
      end
      IDX_OFF_HIGH: begin
        reg_addr = arc_pkg::ADDR_TEMP_OFFSET_HIGH;
      end
      IDX_REG: begin
        reg_addr = arc_pkg::ADDR_REGULATOR_CONTROL;
      end
      default: begin
        reg_addr = arc_pkg::ADDR_REFERENCE_CONTROL;
      end
    endcase
  endfunction

  logic [NUM_REGS-1:0] sel_vec;
  logic wr_ref;
  logic wr_reg;
  logic wr_off_low;
  logic wr_off_high;

  // address decode, one match bit per mapped register
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_dec
    assign sel_vec[g] = addr_is(i_sfr.addr, reg_addr(g));
  end

  // write strobes per register; unmapped writes raise none
  assign wr_ref = i_sfr.wr && sel_vec[IDX_REF];
  assign wr_reg = i_sfr.wr && sel_vec[IDX_REG];
  assign wr_off_low = i_sfr.wr && sel_vec[IDX_OFF_LOW];
  assign wr_off_high = i_sfr.wr && sel_vec[IDX_OFF_HIGH];

  // offset storage
  // the stored code is the raw converter code, so steps match one to one
  arc_offset_store u_offset (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr_high(wr_off_high),
    .i_wr_low(wr_off_low),
    .i_wdata(i_sfr.wdata),
    .i_sel_high(addr_is(i_sfr.addr, arc_pkg::ADDR_TEMP_OFFSET_HIGH)),
    .o_rdata(off_rdata),
    .o_offset(o_sensor_offset_value)
  );

  // reference control storage
  // only bits 4:2 are writable; others stay zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_ctl_r <= arc_pkg::REF_RESET;
    end else if (wr_ref) begin
      ref_ctl_r <= i_sfr.wdata & arc_pkg::REF_WRITE_MASK;
    end
  end

  // regulator control storage, all bits read/write
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_ctl_r <= arc_pkg::REG_RESET;
    end else if (wr_reg) begin
      reg_ctl_r <= i_sfr.wdata;
    end
  end

  always_comb begin
    if (ref_ctl_r[arc_pkg::REF_OVERRIDE_BIT]) begin
      ref_src_nxt = arc_pkg::ARC_REF_REGULATOR;
    end else if (ref_ctl_r[arc_pkg::REF_SELECT_BIT]) begin
      ref_src_nxt = arc_pkg::ARC_REF_SUPPLY;
    end else begin
      ref_src_nxt = arc_pkg::ARC_REF_PIN;
    end
  end

  // registered reference select, one edge after the stored bits
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_src_r <= arc_pkg::ARC_REF_PIN;
    end else begin
      ref_src_r <= ref_src_nxt;
    end
  end

  // read path: registered data and hit flag one cycle after rd
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_rdata_r <= 8'h00_00;
      rd_offset_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      rd_offset_r <= sel_vec[IDX_OFF_LOW] || sel_vec[IDX_OFF_HIGH];
      // hit only for a read of a mapped slot
      hit_r <= i_sfr.rd && (|sel_vec);
      if (addr_is(i_sfr.addr, arc_pkg::ADDR_REFERENCE_CONTROL)) begin
        ref_rdata_r <= ref_ctl_r;
      end else if (addr_is(i_sfr.addr, arc_pkg::ADDR_REGULATOR_CONTROL)) begin
        ref_rdata_r <= reg_ctl_r;
      end else begin
        ref_rdata_r <= 8'h00_00;
      end
    end
  end

  // read data muxed from registered sources; zero when not a hit
  assign o_sfr_hit = hit_r;
  assign o_sfr_rdata = !hit_r ? 8'h00_00 : (rd_offset_r ? off_rdata : ref_rdata_r);

  assign o_ctl.ref_src = ref_src_r;
  assign o_ctl.temp_sensor_enable = ref_ctl_r[arc_pkg::REF_TEMP_EN_BIT];
  assign o_ctl.stop_power_config = reg_ctl_r[arc_pkg::REG_STOP_CFG_BIT];
  // bypass is trusted as written; software keeps it for external supply
  assign o_ctl.regulator_bypass = reg_ctl_r[arc_pkg::REG_BYPASS_BIT];

  assign o_regulator_on = !reg_ctl_r[arc_pkg::REG_BYPASS_BIT]
                       && !(i_stop_mode && reg_ctl_r[arc_pkg::REG_STOP_CFG_BIT]);
  assign o_stop_reset_pin_only = i_stop_mode && reg_ctl_r[arc_pkg::REG_STOP_CFG_BIT];

endmodule // arc_analog_regs

// file: sim/arc_analog_regs_sva.sv
// checker: port-level assertions for the analog ref/cal register bank
`timescale 1ns/1ps
module arc_analog_regs_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire arc_pkg::arc_sfr_req_t i_sfr,
  input wire logic i_stop_mode,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  input wire arc_pkg::arc_analog_ctl_t o_ctl,
  input wire logic o_regulator_on,
  input wire logic o_stop_reset_pin_only,
  input wire logic [9:0] o_sensor_offset_value
);
  logic wref;
  logic wreg;
  // write strobes decoded per register
  assign wref = i_sfr.wr && i_sfr.addr == arc_pkg::ADDR_REFERENCE_CONTROL;
  assign wreg = i_sfr.wr && i_sfr.addr == arc_pkg::ADDR_REGULATOR_CONTROL;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ovr_ref_a: assert property (wref && i_sfr.wdata[4] |=>
    ##1 o_ctl.ref_src == arc_pkg::ARC_REF_REGULATOR) else $error("override not applied");
  sel_ref_a: assert property (wref && !i_sfr.wdata[4] |=> ##1 o_ctl.ref_src ==
    ($past(i_sfr.wdata[3], 2) ? arc_pkg::ARC_REF_SUPPLY : arc_pkg::ARC_REF_PIN))
    else $error("reference select wrong");
  temp_en_a: assert property (wref |=>
    o_ctl.temp_sensor_enable == $past(i_sfr.wdata[2])) else $error("sensor enable wrong");
  stop_cfg_a: assert property (wreg |=>
    o_ctl.stop_power_config == $past(i_sfr.wdata[7])) else $error("stop config wrong");
  bypass_bit_a: assert property (wreg |=>
    o_ctl.regulator_bypass == $past(i_sfr.wdata[6])) else $error("bypass bit wrong");
  stop_pin_a: assert property (o_stop_reset_pin_only ==
    (i_stop_mode && o_ctl.stop_power_config)) else $error("stop shutdown wrong");
  reg_on_a: assert property (!i_stop_mode && !o_ctl.regulator_bypass |->
    o_regulator_on) else $error("regulator off outside stop");
  stop_keep_a: assert property (i_stop_mode && !o_ctl.stop_power_config
    && !o_ctl.regulator_bypass |-> o_regulator_on) else $error("regulator off in stop");
  ref_rd_a: assert property (i_sfr.rd && i_sfr.addr == arc_pkg::ADDR_REFERENCE_CONTROL |=>
    o_sfr_hit && (o_sfr_rdata & 8'hE3) == 8'h00) else $error("reference unused bits set");
  low_rd_a: assert property (i_sfr.rd && i_sfr.addr == arc_pkg::ADDR_TEMP_OFFSET_LOW |=>
    o_sfr_hit && o_sfr_rdata[5:0] == 6'h00) else $error("offset low unused bits set");
  high_map_a: assert property (i_sfr.rd && !i_sfr.wr
    && i_sfr.addr == arc_pkg::ADDR_TEMP_OFFSET_HIGH |=>
    o_sfr_rdata == o_sensor_offset_value[9:2]) else $error("offset high byte wrong");
  cover property (wref && i_sfr.wdata[4]);
  cover property (o_stop_reset_pin_only);
  cover property (o_sfr_hit);
endmodule // arc_analog_regs_chk

bind arc_analog_regs arc_analog_regs_chk i_chk (.i_clk_sys, .i_rst_n, .i_sfr, .i_stop_mode,
  .o_sfr_rdata, .o_sfr_hit, .o_ctl, .o_regulator_on, .o_stop_reset_pin_only,
  .o_sensor_offset_value);

// file: sim/tb_top.sv
// testbench: register-level tests of the analog ref/cal register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_stop_mode = 1'b0;
  arc_pkg::arc_sfr_req_t sfr = '0;
  logic [7:0] rdata;
  logic hit;
  arc_pkg::arc_analog_ctl_t ctl;
  logic reg_on;
  logic pin_only;
  logic [9:0] offs;
  arc_pkg::arc_ref_src_t es;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] vals [4] = '{8'hFF, 8'h13, 8'h0C, 8'hE3};

  arc_analog_regs i_dut (.i_clk_sys, .i_rst_n, .i_sfr(sfr), .i_stop_mode,
    .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_ctl(ctl), .o_regulator_on(reg_on),
    .o_stop_reset_pin_only(pin_only), .o_sensor_offset_value(offs));

  // 10 MHz system clock
  always #50 i_clk_sys = ~i_clk_sys;

  // one write, then wait until the select stage has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    sfr.wr <= 1'b1;
    sfr.addr <= a;
    sfr.wdata <= d;
    @(posedge i_clk_sys);
    sfr.wr <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  // one read; address held through the answer cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    sfr.rd <= 1'b1;
    sfr.addr <= a;
    @(posedge i_clk_sys);
    sfr.rd <= 1'b0;
    #1;
    `CHK("read data", e, rdata)
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(arc_pkg::ADDR_REFERENCE_CONTROL, 8'h00);
    rd(arc_pkg::ADDR_REGULATOR_CONTROL, 8'h00);
    rd(arc_pkg::ADDR_TEMP_OFFSET_HIGH, arc_pkg::OFFSET_DEFAULT[9:2]);
    rd(arc_pkg::ADDR_TEMP_OFFSET_LOW, {arc_pkg::OFFSET_DEFAULT[1:0], 6'h00});
    `CHK("offset", arc_pkg::OFFSET_DEFAULT, offs)
    `CHK("ref source", arc_pkg::ARC_REF_PIN, ctl.ref_src)
    foreach (vals[i]) begin
      wr(arc_pkg::ADDR_REFERENCE_CONTROL, vals[i]);
      es = vals[i][3] ? arc_pkg::ARC_REF_SUPPLY : arc_pkg::ARC_REF_PIN;
      es = vals[i][4] ? arc_pkg::ARC_REF_REGULATOR : es;
      `CHK("ref source", es, ctl.ref_src)
      `CHK("sensor enable", vals[i][2], ctl.temp_sensor_enable)
      rd(arc_pkg::ADDR_REFERENCE_CONTROL, vals[i] & 8'h1C);
    end
    wr(arc_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h5A);
    wr(arc_pkg::ADDR_TEMP_OFFSET_LOW, 8'hFF);
    rd(arc_pkg::ADDR_TEMP_OFFSET_LOW, 8'hC0);
    rd(arc_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h5A);
    `CHK("offset", {8'h5A, 2'b11}, offs)
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b1;
    #1;
    `CHK("regulator on", 1'b1, reg_on)
    `CHK("pin only", 1'b0, pin_only)
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b0;
    wr(arc_pkg::ADDR_REGULATOR_CONTROL, 8'h80);
    `CHK("stop config", 1'b1, ctl.stop_power_config)
    `CHK("regulator on", 1'b1, reg_on)
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b1;
    #1;
    `CHK("pin only", 1'b1, pin_only)
    `CHK("regulator on", 1'b0, reg_on)
    @(posedge i_clk_sys);
    i_stop_mode <= 1'b0;
    wr(arc_pkg::ADDR_REGULATOR_CONTROL, 8'h40);
    `CHK("bypass", 1'b1, ctl.regulator_bypass)
    `CHK("regulator on", 1'b0, reg_on)
    rd(arc_pkg::ADDR_REGULATOR_CONTROL, 8'h40);
    rd(8'h55, 8'h00);
    `CHK("hit", 1'b0, hit)
    // mid-run reset brings back the reset values
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    `CHK("offset", arc_pkg::OFFSET_DEFAULT, offs)
    `CHK("bypass", 1'b0, ctl.regulator_bypass)
    `CHK("ref source", arc_pkg::ARC_REF_PIN, ctl.ref_src)
    rd(arc_pkg::ADDR_REGULATOR_CONTROL, 8'h00);
    end_sim;
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule // tb_top
